// ===== verilog/mipr_pkg.sv
// Constants and types for the module identification page ROM
package mipr_pkg;
    // Byte numbers within the upper memory pages
    localparam logic [7:0] PG_FIRST = 8'h80;
    localparam int PG_BYTES = 128;
    localparam logic [7:0] OFS_APP_CSUM = 8'h80;
    localparam logic [7:0] OFS_APP_LEN = 8'h81;
    localparam logic [7:0] OFS_APP_CODES = 8'h82;
    localparam logic [7:0] OFS_REVISION = 8'hb8;
    localparam logic [7:0] OFS_WAVE = 8'hba;
    localparam logic [7:0] OFS_TOL = 8'hbc;
    localparam logic [7:0] OFS_MAX_TEMP = 8'hbe;
    localparam logic [7:0] OFS_BASE_CSUM = 8'hbf;
    localparam logic [7:0] OFS_EXT_COMP = 8'hc0;
    localparam logic [7:0] OFS_PROG_OPT = 8'hc1;
    localparam logic [7:0] OFS_CHAN_OPT = 8'hc2;
    localparam logic [7:0] OFS_SIG_OPT = 8'hc3;
    localparam logic [7:0] OFS_SERIAL = 8'hc4;
    localparam logic [7:0] OFS_DATE = 8'hd4;
    localparam logic [7:0] OFS_MON_TYPE = 8'hdc;
    localparam logic [7:0] OFS_ENH_OPT = 8'hdd;
    localparam logic [7:0] OFS_EXT_RATE = 8'hde;
    localparam logic [7:0] OFS_EXT_CSUM = 8'hdf;
    // Checksum spans, inclusive
    localparam logic [7:0] BASE_SUM_FIRST = 8'h80;
    localparam logic [7:0] BASE_SUM_LAST = 8'hbe;
    localparam logic [7:0] EXT_SUM_FIRST = 8'hc0;
    localparam logic [7:0] EXT_SUM_LAST = 8'hde;
    localparam logic [7:0] APP_SUM_FIRST = 8'h81;
    localparam logic [7:0] APP_SUM_LAST = 8'hff;
    // Word index map of the bus, byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h000;
    localparam logic [9:0] IDX_STATUS = 10'h001;
    localparam logic [2:0] REGION_PG0 = 3'h1;
    localparam logic [2:0] REGION_PG1 = 3'h3;
    // Bit positions
    localparam int BIT_PAGE02 = 7;
    localparam int BIT_PAGE01 = 6;
    localparam int BIT_RATE_CTRL = 5;
    localparam int BIT_RX_PWR_AVG = 3;
    localparam int BIT_EXT_RATE_SEL = 3;
    localparam int BIT_APP_SEL = 2;
    localparam int CTRL_WFAULT = 0;
    localparam int STAT_CONFLICT = 0;
    localparam int STAT_LEGACY_FULL = 1;
    localparam int STAT_PAGE01 = 2;
    // Values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ASCII_SPACE = 8'h20;
    localparam logic [7:0] LEGACY_RATE_FULL = 8'hff;
    localparam logic [7:0] CASE_TEMP_DEFAULT = 8'h46;
    localparam int APP_MAX_ENTRIES = 63;
    // Bus slave sequencing
    typedef enum logic [1:0] {
        MIPR_IDLE,
        MIPR_FETCH,
        MIPR_DONE
    } mipr_state_t;
endpackage : mipr_pkg

// ===== verilog/mipr_id_rom.sv
// Byte-wide constant page image with a registered read port
`timescale 1ns/1ns
module mipr_id_rom #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter logic [DEPTH*8-1:0] IMAGE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data_reg
);
    logic [7:0] rom [DEPTH];

    // One entry per byte of the image; no write port exists at all
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            assign rom[gi] = IMAGE[gi*8 +: 8];
        end
    endgenerate

    // Registered read keeps the bus answer off a wide mux path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
        end else if (rd_en) begin
            rd_data_reg <= rom[rd_addr];
        end
    end
endmodule : mipr_id_rom

// ===== verilog/mipr_top.sv
// Identification page ROM of a pluggable module, read over APB
// Behaviour
// - Revision is two space padded ASCII bytes
// - Optical bytes 186-187 hold wavelength times twenty
// - Copper bytes 186-187 hold low attenuations
// - Optical bytes 188-189 hold tolerance times two hundred
// - Copper bytes 188-189 hold high attenuations
// - Case temperature byte, zero means seventy
// - Base checksum sums bytes 128 to 190
// - Byte 193 low bits flag programming options
// - Byte 194 flags clock recovery and squelch
// - Byte 195 flags pages 02 and 01
// - Byte 195 bit 5 demands active rate control
// - Byte 195 bits 4-1 flag signal options
// - Serial number is sixteen padded ASCII bytes
// - Date code holds year, month, day, lot
// - Byte 220 bit 3 flags average power
// - Byte 221 bit 3 flags extended rate select
// - Byte 221 bit 2 flags application table
// - Never report both rate declarations set
// - Byte 222 holds rate in 250 Mbps steps
// - Extension checksum sums bytes 192 to 222
// - Application page checksum sums bytes 129-255
// - Byte 129 holds last application entry index
// - Legacy rate FFh points host to byte 222
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module mipr_top #(
    parameter bit COPPER = 1'b0,
    parameter logic [15:0] WAVELENGTH = 16'h6626,
    parameter logic [15:0] TOLERANCE = 16'h251c,
    parameter logic [31:0] ATTENUATION = 32'h00000000,
    parameter logic [15:0] REVISION = 16'h4120,
    parameter logic [7:0] MAX_CASE_TEMP = 8'h00,
    parameter logic [7:0] EXT_COMPLIANCE = 8'h00,
    parameter logic [2:0] PROG_OPTS = 3'h0,
    parameter logic [7:0] CHAN_OPTS = 8'h00,
    parameter bit PAGE02 = 1'b0,
    parameter bit RATE_CTRL = 1'b0,
    parameter logic [3:0] SIG_OPTS = 4'h0,
    parameter logic [127:0] SERIAL = {16{8'h20}},
    parameter logic [63:0] DATE = 64'h3030303130312020,
    parameter bit RX_PWR_AVG = 1'b0,
    parameter bit EXT_RATE_SEL = 1'b0,
    parameter bit APP_SEL = 1'b0,
    parameter logic [7:0] EXT_RATE = 8'h00,
    parameter logic [7:0] LEGACY_RATE = 8'h00,
    parameter logic [5:0] APP_LAST = 6'h00,
    parameter logic [1007:0] APP_CODES = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    localparam int IMG_W = mipr_pkg::PG_BYTES * 8;

    // Both rate declarations set is illegal; the table wins
    localparam bit CONFLICT = EXT_RATE_SEL && APP_SEL;
    localparam bit EXT_EFF = EXT_RATE_SEL && !APP_SEL;
    localparam bit APP_EFF = APP_SEL;

    // Place n bytes of v, first character at the lowest address
    function automatic logic [IMG_W-1:0] put(
        input logic [IMG_W-1:0] img,
        input logic [7:0] ofs,
        input logic [127:0] v,
        input int n
    );
        logic [IMG_W-1:0] r;
        int base;
        r = img;
        base = int'(ofs) - int'(mipr_pkg::PG_FIRST);
        for (int i = 0; i < n; i++) begin
            r[(base + i)*8 +: 8] = v[(n - 1 - i)*8 +: 8];
        end
        return r;
    endfunction : put

    // Low eight bits of the byte sum over an inclusive span
    function automatic logic [7:0] csum(
        input logic [IMG_W-1:0] img,
        input logic [7:0] first,
        input logic [7:0] last
    );
        logic [7:0] s;
        s = 8'h00;
        for (int a = int'(first); a <= int'(last); a++) begin
            s = s + img[(a - int'(mipr_pkg::PG_FIRST))*8 +: 8];
        end
        return s;
    endfunction : csum

    // Identification page image, checksums folded in last
    function automatic logic [IMG_W-1:0] build_pg0();
        logic [IMG_W-1:0] m;
        logic [15:0] wave;
        logic [15:0] tol;
        m = '0;
        m = put(m, mipr_pkg::OFS_REVISION, 128'(REVISION), 2);
        // Copper reuses the wavelength bytes for attenuation
        wave = COPPER ? ATTENUATION[31:16] : WAVELENGTH;
        tol = COPPER ? ATTENUATION[15:0] : TOLERANCE;
        m = put(m, mipr_pkg::OFS_WAVE, 128'(wave), 2);
        m = put(m, mipr_pkg::OFS_TOL, 128'(tol), 2);
        m = put(m, mipr_pkg::OFS_MAX_TEMP, 128'(MAX_CASE_TEMP), 1);
        m = put(m, mipr_pkg::OFS_EXT_COMP, 128'(EXT_COMPLIANCE), 1);
        m = put(m, mipr_pkg::OFS_PROG_OPT, 128'({5'h00, PROG_OPTS}), 1);
        m = put(m, mipr_pkg::OFS_CHAN_OPT, 128'(CHAN_OPTS), 1);
        // Page 01 flag follows the table declaration so they never disagree
        m = put(m, mipr_pkg::OFS_SIG_OPT,
            128'({PAGE02, APP_EFF, RATE_CTRL, SIG_OPTS, 1'b0}), 1);
        m = put(m, mipr_pkg::OFS_SERIAL, SERIAL, 16);
        m = put(m, mipr_pkg::OFS_DATE, 128'(DATE), 8);
        m = put(m, mipr_pkg::OFS_MON_TYPE,
            128'({4'h0, RX_PWR_AVG, 3'h0}), 1);
        m = put(m, mipr_pkg::OFS_ENH_OPT,
            128'({4'h0, EXT_EFF, APP_EFF, 2'h0}), 1);
        m = put(m, mipr_pkg::OFS_EXT_RATE, 128'(EXT_RATE), 1);
        m = put(m, mipr_pkg::OFS_BASE_CSUM, 128'(csum(m,
            mipr_pkg::BASE_SUM_FIRST, mipr_pkg::BASE_SUM_LAST)), 1);
        m = put(m, mipr_pkg::OFS_EXT_CSUM, 128'(csum(m,
            mipr_pkg::EXT_SUM_FIRST, mipr_pkg::EXT_SUM_LAST)), 1);
        return m;
    endfunction : build_pg0

    // Application page image; entries past the last index stay zero
    function automatic logic [IMG_W-1:0] build_pg1();
        logic [IMG_W-1:0] m;
        int ofs;
        m = '0;
        m = put(m, mipr_pkg::OFS_APP_LEN, 128'({2'h0, APP_LAST}), 1);
        for (int e = 0; e < mipr_pkg::APP_MAX_ENTRIES; e++) begin
            if (e <= int'(APP_LAST)) begin
                ofs = int'(mipr_pkg::OFS_APP_CODES) + 2*e;
                m = put(m, 8'(ofs), 128'(APP_CODES[e*16 +: 16]), 2);
            end
        end
        m = put(m, mipr_pkg::OFS_APP_CSUM, 128'(csum(m,
            mipr_pkg::APP_SUM_FIRST, mipr_pkg::APP_SUM_LAST)), 1);
        return m;
    endfunction : build_pg1

    localparam logic [IMG_W-1:0] PG0_IMAGE = build_pg0();
    localparam logic [IMG_W-1:0] PG1_IMAGE = build_pg1();

    // Effective case temperature for the status word
    localparam logic [7:0] CASE_TEMP_EFF = (MAX_CASE_TEMP == 8'h00) ?
        mipr_pkg::CASE_TEMP_DEFAULT : MAX_CASE_TEMP;
    localparam bit LEGACY_FULL =
        (LEGACY_RATE == mipr_pkg::LEGACY_RATE_FULL);

    mipr_pkg::mipr_state_t state_reg;
    logic [9:0] idx_reg;
    logic [7:0] ctrl_reg;
    logic [9:0] idx_next;
    logic setup;
    logic aligned;
    logic rd_pg0;
    logic rd_pg1;
    logic [7:0] pg0_data;
    logic [7:0] pg1_data;
    logic [31:0] rdata_next;
    logic err_next;
    logic is_ctrl;
    logic is_status;
    logic is_pg0;
    logic is_pg1;

    // Setup cycle decode; page fetch starts a cycle early
    assign setup = (state_reg == mipr_pkg::MIPR_IDLE) && psel && !penable;
    assign idx_next = paddr[11:2];
    assign rd_pg0 = setup && (idx_next[9:7] == mipr_pkg::REGION_PG0);
    assign rd_pg1 = setup && (idx_next[9:7] == mipr_pkg::REGION_PG1);

    mipr_id_rom #(
        .DEPTH(mipr_pkg::PG_BYTES),
        .AW(7),
        .IMAGE(PG0_IMAGE)
    ) u_pg0 (
        .clk(clk),
        .rst(rst),
        .rd_en(rd_pg0),
        .rd_addr(idx_next[6:0]),
        .rd_data_reg(pg0_data)
    );

    mipr_id_rom #(
        .DEPTH(mipr_pkg::PG_BYTES),
        .AW(7),
        .IMAGE(PG1_IMAGE)
    ) u_pg1 (
        .clk(clk),
        .rst(rst),
        .rd_en(rd_pg1),
        .rd_addr(idx_next[6:0]),
        .rd_data_reg(pg1_data)
    );

    // Access phase decode on the held index
    assign is_ctrl = (idx_reg == mipr_pkg::IDX_CTRL);
    assign is_status = (idx_reg == mipr_pkg::IDX_STATUS);
    assign is_pg0 = (idx_reg[9:7] == mipr_pkg::REGION_PG0);
    // An absent application page answers like an unmapped address
    assign is_pg1 = (idx_reg[9:7] == mipr_pkg::REGION_PG1) && APP_EFF;

    // Read data and error answer, settled before pready rises
    always_comb begin
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        if (!aligned) begin
            err_next = 1'b1;
        end else if (is_ctrl) begin
            rdata_next = {24'h000000, ctrl_reg};
        end else if (is_status) begin
            rdata_next = {16'h0000, CASE_TEMP_EFF, 5'h00, APP_EFF,
                LEGACY_FULL, CONFLICT};
            err_next = pwrite && ctrl_reg[mipr_pkg::CTRL_WFAULT];
        end else if (is_pg0 || is_pg1) begin
            rdata_next = {24'h000000, is_pg0 ? pg0_data : pg1_data};
            // Writes are dropped; faulting them is optional
            err_next = pwrite && ctrl_reg[mipr_pkg::CTRL_WFAULT];
        end else begin
            err_next = 1'b1;
        end
    end

    // Transfer sequencing: setup, one fetch cycle, then the ready cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= mipr_pkg::MIPR_IDLE;
        end else begin
            unique case (state_reg)
                mipr_pkg::MIPR_IDLE: begin
                    if (setup) begin
                        state_reg <= mipr_pkg::MIPR_FETCH;
                    end
                end
                mipr_pkg::MIPR_FETCH: begin
                    if (psel && penable) begin
                        state_reg <= mipr_pkg::MIPR_DONE;
                    end
                end
                mipr_pkg::MIPR_DONE: begin
                    state_reg <= mipr_pkg::MIPR_IDLE;
                end
            endcase
        end
    end

    // Address capture at the setup edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_reg <= 10'h000;
            aligned <= 1'b1;
        end else if (setup) begin
            idx_reg <= idx_next;
            aligned <= (paddr[1:0] == 2'h0);
        end
    end

    // Answer registers; every output comes straight from here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (state_reg == mipr_pkg::MIPR_FETCH && psel && penable) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rdata_next;
            pslverr <= err_next;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // Control write lands only at the edge that completes the transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= mipr_pkg::CTRL_RESET;
        end else if (pready && pwrite && is_ctrl && aligned && pstrb[0]) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    // Read answers after exactly two access cycles
    a_read_timing: assert property (@(posedge clk) disable iff (rst)
        setup |=> !pready ##1 pready)
        else $error("ready not on second access cycle");

    a_ready_single: assert property (@(posedge clk) disable iff (rst)
        pready |=> !pready)
        else $error("ready held past one cycle");

    a_ro_write_kept: assert property (@(posedge clk) disable iff (rst)
        (pready && pwrite && !is_ctrl) |=> ctrl_reg == $past(ctrl_reg))
        else $error("write outside control changed state");

    a_base_csum: assert property (@(posedge clk) disable iff (rst)
        (pready && !pwrite && !pslverr
            && idx_reg == {2'h0, mipr_pkg::OFS_BASE_CSUM})
        |-> prdata[7:0] == csum(PG0_IMAGE, mipr_pkg::BASE_SUM_FIRST,
            mipr_pkg::BASE_SUM_LAST))
        else $error("base checksum wrong");

    a_ext_csum: assert property (@(posedge clk) disable iff (rst)
        (pready && !pwrite && !pslverr
            && idx_reg == {2'h0, mipr_pkg::OFS_EXT_CSUM})
        |-> prdata[7:0] == csum(PG0_IMAGE, mipr_pkg::EXT_SUM_FIRST,
            mipr_pkg::EXT_SUM_LAST))
        else $error("extension checksum wrong");

    a_app_csum: assert property (@(posedge clk) disable iff (rst)
        (pready && !pwrite && !pslverr
            && idx_reg == {2'h1, mipr_pkg::OFS_APP_CSUM})
        |-> prdata[7:0] == csum(PG1_IMAGE, mipr_pkg::APP_SUM_FIRST,
            mipr_pkg::APP_SUM_LAST))
        else $error("application checksum wrong");

    a_rate_decl_excl: assert property (@(posedge clk) disable iff (rst)
        (pready && !pwrite && idx_reg == {2'h0, mipr_pkg::OFS_ENH_OPT})
        |-> !(prdata[mipr_pkg::BIT_EXT_RATE_SEL] && prdata[mipr_pkg::BIT_APP_SEL]))
        else $error("both rate declarations reported");

    a_page01_absent: assert property (@(posedge clk) disable iff (rst)
        (setup && idx_next[9:7] == mipr_pkg::REGION_PG1 && !APP_EFF)
        |-> ##2 (pready && pslverr))
        else $error("absent page answered");

    a_page01_flag: assert property (@(posedge clk) disable iff (rst)
        (pready && !pwrite && idx_reg == {2'h0, mipr_pkg::OFS_SIG_OPT})
        |-> prdata[mipr_pkg::BIT_PAGE01] == APP_EFF)
        else $error("page 01 flag disagrees");

    a_case_temp: assert property (@(posedge clk) disable iff (rst)
        (pready && !pwrite && is_status && aligned)
        |-> prdata[15:8] == CASE_TEMP_EFF && prdata[15:8] != 8'h00)
        else $error("case temperature status wrong");
endmodule : mipr_top

// ===== tb/mipr_host.sv
// APB master model standing in for the host management controller
`timescale 1ns/1ns
module mipr_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // Bus idles low from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
    end

    // One transfer, entered just after a rising edge; psel stays up so the
    // next call can follow back to back, and penable is only lowered here
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the bench watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
    endtask : xfer

    // Release the bus for one cycle
    task automatic idle();
        psel <= 1'b0;
        @(posedge clk);
    endtask : idle
endmodule : mipr_host

// ===== tb/tb_module_id_page_rom.sv
// Self-checking bench for the identification page ROM
`timescale 1ns/1ns
module tb_module_id_page_rom;
    localparam logic [15:0] WAVE = 16'h77dd;
    localparam logic [15:0] TOL = 16'h002f;
    localparam logic [31:0] ATT = 32'h0a141e2b;
    localparam logic [15:0] REV = 16'h4231;
    localparam logic [127:0] SER = "SN7734          ";
    localparam logic [63:0] DCODE = "240517AB";
    localparam logic [63:0] APPS = 64'h4455110322073301; // Entry 3 lies past the last index
    localparam logic [2:0] PROG = 3'h5;
    localparam logic [7:0] CHAN = 8'ha5;
    localparam logic [3:0] SIG = 4'ha;
    localparam logic [7:0] EXTR = 8'h64;
    localparam logic [7:0] EXTC = 8'h3c;
    localparam bit PG2 = 1'b1;
    localparam bit RCTL = 1'b1;
    localparam bit RXAVG = 1'b1;
    localparam bit XRS = 1'b1; // Both devices declare extended rate select
    localparam bit TBL_OPT = 1'b1; // Optical declares the table too, a conflict
    localparam bit TBL_CU = 1'b0; // Copper has no page 01
    localparam logic [5:0] LAST = 6'h02;
    localparam logic [7:0] LRATE = 8'hff;
    localparam logic [7:0] LRATE_CU = 8'h64; // Below the legacy limit
    localparam logic [7:0] CTEMP = 8'h55; // Copper case limit, nonzero
    localparam logic [1007:0] APP_ALL = {944'h0, APPS};
    logic clk, rst, cu, psel, penable, pwrite, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0] pstrb;
    logic pready0, pready1, pslverr0, pslverr1, pready_m, pslverr_m;
    logic [31:0] prdata0, prdata1, prdata_m;
    int n_errors, check_count, seed, b;
    bit p;

    // Clock and the answer mux between the optical and the copper device
    initial clk = 1'b0;
    always #10 clk = ~clk;
    assign pready_m = cu ? pready1 : pready0;
    assign prdata_m = cu ? prdata1 : prdata0;
    assign pslverr_m = cu ? pslverr1 : pslverr0;

    mipr_top #(.COPPER(1'b0), .WAVELENGTH(WAVE), .TOLERANCE(TOL), .ATTENUATION(ATT),
        .REVISION(REV), .EXT_COMPLIANCE(EXTC), .PROG_OPTS(PROG), .CHAN_OPTS(CHAN),
        .PAGE02(PG2), .RATE_CTRL(RCTL), .SIG_OPTS(SIG), .SERIAL(SER), .DATE(DCODE),
        .RX_PWR_AVG(RXAVG), .EXT_RATE_SEL(XRS), .APP_SEL(TBL_OPT), .EXT_RATE(EXTR),
        .LEGACY_RATE(LRATE), .APP_LAST(LAST), .APP_CODES(APP_ALL)) i_dut (
        .clk(clk), .rst(rst), .psel(psel & ~cu), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready0),
        .prdata(prdata0), .pslverr(pslverr0));
    mipr_top #(.COPPER(1'b1), .WAVELENGTH(WAVE), .TOLERANCE(TOL), .ATTENUATION(ATT),
        .REVISION(REV), .MAX_CASE_TEMP(CTEMP), .EXT_COMPLIANCE(EXTC), .PROG_OPTS(PROG),
        .CHAN_OPTS(CHAN), .PAGE02(PG2), .RATE_CTRL(RCTL), .SIG_OPTS(SIG), .SERIAL(SER),
        .DATE(DCODE), .RX_PWR_AVG(RXAVG), .EXT_RATE_SEL(XRS), .APP_SEL(TBL_CU),
        .EXT_RATE(EXTR), .LEGACY_RATE(LRATE_CU), .APP_LAST(LAST), .APP_CODES(APP_ALL))
        i_dut_cu (
        .clk(clk), .rst(rst), .psel(psel & cu), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready1),
        .prdata(prdata1), .pslverr(pslverr1));
    mipr_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready_m),
        .prdata(prdata_m), .pslverr(pslverr_m));

    // Expected stored byte, checksum places left at zero
    function automatic logic [7:0] img(input bit c, input bit pg, input int n);
        if (pg) begin
            if (n == 129) return {2'h0, LAST};
            if (n >= 130 && n <= 131 + 2 * int'(LAST))
                return APPS[(n - 130) / 2 * 16 + ((n % 2) ? 0 : 8) +: 8];
            return 8'h00;
        end
        case (n)
            184: return REV[15:8];
            185: return REV[7:0];
            186: return c ? ATT[31:24] : WAVE[15:8];
            187: return c ? ATT[23:16] : WAVE[7:0];
            188: return c ? ATT[15:8] : TOL[15:8];
            189: return c ? ATT[7:0] : TOL[7:0];
            190: return c ? CTEMP : 8'h00;
            192: return EXTC;
            193: return {5'h00, PROG};
            194: return CHAN;
            195: return {PG2, c ? TBL_CU : TBL_OPT, RCTL, SIG, 1'b0};
            220: return {4'h0, RXAVG, 3'h0};
            221: return c ? 8'h08 : 8'h04;
            222: return EXTR;
            default: ;
        endcase
        if (n >= 196 && n <= 211) return SER[(211 - n) * 8 +: 8];
        if (n >= 212 && n <= 219) return DCODE[(219 - n) * 8 +: 8];
        return 8'h00;
    endfunction : img

    // Expected read value, checksums summed here over their spans
    function automatic logic [7:0] expb(input bit c, input bit pg, input int n);
        logic [7:0] s;
        int lo, hi;
        s = 8'h00;
        lo = pg ? 129 : (n == 191 ? 128 : 192);
        hi = pg ? 255 : (n == 191 ? 190 : 222);
        if ((pg && n == 128) || (!pg && (n == 191 || n == 223))) begin
            for (int i = lo; i <= hi; i++) s = s + img(c, pg, i);
            return s;
        end
        return img(c, pg, n);
    endfunction : expb

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Read a span of bytes of one page and compare each word
    task automatic sweep(input bit c, input bit pg, input int lo, input int hi);
        for (int n = lo; n <= hi; n++) begin
            i_host.xfer(1'b0, 12'((pg * 256 + n) * 4), 32'h0, 4'h0, rd, er);
            chk($sformatf("page %0d byte %0d", pg, n), {24'h0, expb(c, pg, n)}, rd);
            chk("read error", 32'h0, {31'h0, er});
        end
    endtask : sweep

    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input string nm, input logic [31:0] e, input logic ee);
        i_host.xfer(w, a, d, s, rd, er);
        chk(nm, e, rd);
        chk({nm, " error"}, {31'h0, ee}, {31'h0, er});
    endtask : acc

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Watchdog, far beyond the roughly sixteen hundred cycles of traffic
    initial begin
        #1000000;
        n_errors++;
        conclude();
    end

    initial begin
        seed = 2322;
        n_errors = 0;
        check_count = 0;
        cu = 1'b0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(1'b0, 12'h000, 32'h0, 4'h0, "ctrl", 32'h0, 1'b0);
        acc(1'b0, 12'h004, 32'h0, 4'h0, "status", 32'h00004607, 1'b0);
        $display("test reset values done");
        sweep(1'b0, 1'b0, 128, 191);
        sweep(1'b0, 1'b0, 192, 195);
        sweep(1'b0, 1'b0, 196, 219);
        sweep(1'b0, 1'b0, 220, 255);
        sweep(1'b0, 1'b1, 128, 255);
        $display("test optical image done");
        acc(1'b0, 12'h201, 32'h0, 4'h0, "unaligned", 32'h0, 1'b1);
        acc(1'b0, 12'h008, 32'h0, 4'h0, "unmapped", 32'h0, 1'b1);
        // Random writes into the image complete quietly and change nothing
        repeat (100) begin
            b = 128 + ($random(seed) & 127);
            p = 1'($random(seed));
            acc(1'b1, 12'((p * 256 + b) * 4), $random(seed), 4'hf, "ro write", 32'h0, 1'b0);
            sweep(1'b0, p, b, b);
        end
        $display("test random writes done");
        // Strict mode refuses image writes; control ignores a write without strobe
        acc(1'b1, 12'h000, 32'h1, 4'h1, "ctrl set", 32'h0, 1'b0);
        acc(1'b1, 12'h000, 32'h0, 4'h0, "ctrl nostrb", 32'h0, 1'b0);
        acc(1'b0, 12'h000, 32'h0, 4'h0, "ctrl held", 32'h1, 1'b0);
        acc(1'b1, 12'h2e8, 32'hff, 4'hf, "strict write", 32'h0, 1'b1);
        acc(1'b1, 12'h004, 32'hff, 4'hf, "status write", 32'h0, 1'b1);
        sweep(1'b0, 1'b0, 186, 187);
        acc(1'b1, 12'h000, 32'h0, 4'h1, "ctrl clear", 32'h0, 1'b0);
        acc(1'b0, 12'h000, 32'h0, 4'h0, "ctrl cleared", 32'h0, 1'b0);
        // Reset in mid-run must clear a control bit left set
        acc(1'b1, 12'h000, 32'h1, 4'h1, "ctrl preset", 32'h0, 1'b0);
        i_host.idle();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(1'b0, 12'h000, 32'h0, 4'h0, "ctrl after reset", 32'h0, 1'b0);
        $display("test strict mode done");
        i_host.idle();
        cu <= 1'b1;
        @(posedge clk);
        acc(1'b0, 12'h004, 32'h0, 4'h0, "cu status", 32'h00005500, 1'b0);
        sweep(1'b1, 1'b0, 184, 191);
        sweep(1'b1, 1'b0, 192, 223);
        acc(1'b0, 12'h600, 32'h0, 4'h0, "no page 01", 32'h0, 1'b1);
        $display("test copper image done");
        i_host.idle();
        conclude();
    end
endmodule : tb_module_id_page_rom
